/* core/scl_loader.sv */
// Configuration loader: flash fetch, passive load, chain handshake, startup.
// Assumes pins are resolved outside; config_clock domain handles the link.
`timescale 1ns/10ps
module scl_loader
   import scl_pkg::*;
#(
   parameter int    IMAGE_BITS = 64,
   parameter int    CD2UM_CYC  = SCL_CD2UM_CYC,
   parameter int    UM_USR_PER = SCL_UM_USR_PER,
   parameter int    DIV        = 4
) (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        cfg_clk_in,
   input  wire logic        user_supplied_clock,
   input  wire logic [3:0]  scheme_select,
   input  wire logic        use_user_clock,
   input  wire logic        chain_enable_in_n,
   input  wire logic        serial_data_in,
   input  wire logic [15:0] par_data_in,
   input  wire logic        par_wide,
   input  wire logic        config_status_n_in,
   input  wire logic        config_complete_in,
   input  wire logic        crc_load_req,
   input  wire logic [31:0] crc_load_value,
   output logic             config_clock_o,
   output logic             config_clock_oe,
   output logic             flash_select_n_out,
   output logic             flash_select_n_oe,
   output logic             active_serial_cmd_out,
   output logic             active_serial_cmd_oe,
   output logic             config_status_n_oe,
   output logic             config_complete_oe,
   output logic             chain_enable_out_n,
   output logic             user_mode,
   output logic             init_busy,
   output logic [31:0]      crc_store
);
   // Strap decode: upper pair zero is parallel, low pair 00 or 10 is passive serial
   function automatic scl_scheme_type scl_decode(input logic [3:0] sel);
      if (sel[3:2] == 2'b00)
         return SCL_FAST_PAR;
      else if (sel[1:0] == 2'b00 || sel[1:0] == 2'b10)
         return SCL_PASSIVE_SERIAL;
      else
         return SCL_ACTIVE_SERIAL;
   endfunction : scl_decode

   // Bits carried by one host clock edge
   function automatic logic [15:0] scl_step_bits(input scl_scheme_type sch, input logic wide);
      if (sch == SCL_FAST_PAR || sch == SCL_ACTIVE_PAR)
         return wide ? 16'h0010 : 16'h0008;
      else
         return 16'h0001;
   endfunction : scl_step_bits

   // Passive link: captures on the host clock, hands a done toggle across
   typedef struct packed {
      logic [15:0] cnt;
      logic        tog;
   } scl_link_type;
   scl_link_type lk_q, lk_d;
   logic [15:0]  lk_step;

   always_comb begin
      lk_d = lk_q;
      // One bit per rising edge in serial; parallel moves 8 or 16 bits
      if (lk_q.cnt < 16'(IMAGE_BITS)) begin
         lk_d.cnt = lk_q.cnt + lk_step;
         if (lk_d.cnt >= 16'(IMAGE_BITS))
            lk_d.tog = ~lk_q.tog;
      end
   end

   // Steady clock after load does nothing: count already saturated
   always_ff @(posedge cfg_clk_in or negedge rst_b) begin
      if (!rst_b)
         lk_q <= '0;
      else
         lk_q <= lk_d;
   end

   typedef struct packed {
      scl_state_type  st;
      scl_scheme_type sch;
      logic [1:0]     ce_s;
      logic [1:0]     cd_s;
      logic [1:0]     tg_s;
      logic [1:0]     uc_s;
      logic           tg_old;
      logic           uc_old;
      logic [31:0]    cnt;
      logic [15:0]    bits;
      logic [7:0]     div;
      logic           sck;
      logic [31:0]    sh;
      logic           cso_n;
      logic           sck_oe;
      logic           cmd_oe;
      logic           st_oe;
      logic           cd_oe;
      logic           ceo_n;
      logic           user;
      logic           init;
      logic [31:0]    crc;
      logic           latched;
      logic [1:0]     lat_cnt;
      logic [1:0]     st_s;
      logic [1:0]     uu_s;
      logic [1:0]     pw_s;
      logic [3:0]     ss0;
      logic [3:0]     ss1;
      logic           wide;
   } scl_core_type;
   scl_core_type q, d;

   logic sck_rise;
   logic sck_fall;
   logic uc_rise;

   // Scheme and width freeze before chain enable can start a load, and the host
   // may not clock before the settle time, so this quasi-static word is safe here
   assign lk_step = scl_step_bits(q.sch, q.wide);

   always_comb begin
      d = q;
      d.ce_s = {q.ce_s[0], chain_enable_in_n};
      d.cd_s = {q.cd_s[0], config_complete_in};
      d.tg_s = {q.tg_s[0], lk_q.tog};
      d.uc_s = {q.uc_s[0], user_supplied_clock};
      d.st_s = {q.st_s[0], config_status_n_in};
      d.uu_s = {q.uu_s[0], use_user_clock};
      d.pw_s = {q.pw_s[0], par_wide};
      d.ss0 = scheme_select;
      d.ss1 = q.ss0;
      d.tg_old = q.tg_s[1];
      d.uc_old = q.uc_s[1];
      uc_rise = q.uc_s[1] & ~q.uc_old;
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      // Strap read once it has passed both sync stages; never changed later
      if (!q.latched) begin
         d.lat_cnt = q.lat_cnt + 2'h1;
         if (q.lat_cnt == SCL_LAT_EDGES) begin
            d.latched = 1'b1;
            d.sch = scl_decode(q.ss1);
            d.wide = q.pw_s[1];
         end
      end
      unique case (q.st)
         SCL_IDLE: begin
            d.cd_oe = 1'b1;
            d.st_oe = 1'b0;
            // Load waits for the shared status line to read high
            if (q.latched && !q.ce_s[1] && q.st_s[1]) begin
               if (q.sch == SCL_ACTIVE_SERIAL) begin
                  d.st = SCL_CMD;
                  d.cso_n = 1'b0;
                  d.sck_oe = 1'b1;
                  d.cmd_oe = 1'b1;
                  d.sh = {SCL_READ_OP, 24'h0};
                  d.bits = 16'h0;
               end else
                  d.st = SCL_LOAD;
            end
         end
         SCL_CMD, SCL_LOAD: begin
            if (q.st == SCL_CMD || q.sch == SCL_ACTIVE_SERIAL) begin
               d.div = q.div + 8'h1;
               if (q.div == 8'(DIV - 1)) begin
                  d.div = 8'h0;
                  d.sck = ~q.sck;
                  sck_rise = ~q.sck;
                  sck_fall = q.sck;
               end
            end
            // Next command bit moves on the fall, so it is steady at the flash's rise
            if (sck_fall && q.st == SCL_CMD)
               d.sh = {q.sh[30:0], 1'b0};
            if (sck_rise) begin
               d.bits = q.bits + 16'h1;
               if (q.st == SCL_CMD) begin
                  if (q.bits == 16'(SCL_CMD_BITS - 1)) begin
                     d.st = SCL_LOAD;
                     d.bits = 16'h0;
                  end
               end else if (q.bits == 16'(IMAGE_BITS - 1))
                  d.st = SCL_DONE;
            end
            if (q.st == SCL_LOAD && q.sch != SCL_ACTIVE_SERIAL && q.tg_s[1] != q.tg_old)
               d.st = SCL_DONE;
         end
         SCL_DONE: begin
            d.ceo_n = 1'b0;
            d.cd_oe = 1'b0;
            d.cso_n = 1'b1;
            d.sck = 1'b0;
            d.sck_oe = 1'b0;
            d.cmd_oe = 1'b0;
            d.cnt = 32'h0;
            if (q.cd_s[1]) begin
               d.st = SCL_INIT;
               d.init = 1'b1;
            end
         end
         SCL_INIT: begin
            if (q.uu_s[1]) begin
               if (uc_rise)
                  d.cnt = q.cnt + 32'h1;
               if (q.cnt == 32'(SCL_CD2CU_PER + UM_USR_PER))
                  d.st = SCL_USER;
            end else begin
               d.cnt = q.cnt + 32'h1;
               if (q.cnt == 32'(CD2UM_CYC - 1))
                  d.st = SCL_USER;
            end
            if (d.st == SCL_USER) begin
               d.user = 1'b1;
               d.init = 1'b0;
            end
         end
         SCL_USER: begin
            if (crc_load_req)
               d.crc = crc_load_value;
         end
         default: d.st = SCL_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.st <= SCL_IDLE;
         q.cso_n <= 1'b1;
         q.ceo_n <= 1'b1;
         q.cd_oe <= 1'b1;
         q.crc <= SCL_CRC_RST;
      end else
         q <= d;
   end

   assign config_clock_o        = q.sck;
   assign config_clock_oe       = q.sck_oe;
   assign flash_select_n_out    = q.cso_n;
   assign flash_select_n_oe     = q.sck_oe;
   assign active_serial_cmd_out = q.sh[31];
   assign active_serial_cmd_oe  = q.cmd_oe;
   assign config_status_n_oe    = q.st_oe;
   assign config_complete_oe    = q.cd_oe;
   assign chain_enable_out_n    = q.ceo_n;
   assign user_mode             = q.user;
   assign init_busy             = q.init;
   assign crc_store             = q.crc;

   crc_user_only_a: assert property (@(posedge mclk) disable iff (!rst_b)
      $changed(q.crc) |-> q.user) else $error("crc store changed outside user mode");
   done_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !q.cd_oe |-> !q.ceo_n) else $error("done released before chain enable");
   select_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (q.st == SCL_CMD) |-> !q.cso_n) else $error("flash not selected");
   pins_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
      q.user |-> !q.sck_oe && !q.cmd_oe) else $error("pins driven in user mode");
   init_go_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (q.st == SCL_DONE && q.cd_s[1]) |=> q.init) else $error("init missed");
   status_od_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !q.st_oe) else $error("status driven");
   hold_done_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (q.st == SCL_LOAD) |-> q.cd_oe) else $error("done released early");
   user_after_a: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(q.user) |-> $past(q.st) == SCL_INIT) else $error("user mode skipped init");

   // Multi-step behaviours from named sequences, then plain single-cycle and next-cycle checks
   sequence cmd_start_s;
      (q.st == SCL_IDLE) ##1 (q.st == SCL_CMD);
   endsequence
   sequence flash_drive_s;
      !q.cso_n && q.sck_oe && q.cmd_oe;
   endsequence
   sequence load_end_s;
      (q.st == SCL_LOAD) ##1 (q.st == SCL_DONE);
   endsequence
   sequence chain_pass_s;
      !q.ceo_n && !q.cd_oe && !q.sck_oe && !q.cmd_oe && q.cso_n;
   endsequence
   sequence init_end_s;
      q.init ##1 !q.init;
   endsequence

   cmd_pins_a: assert property (@(posedge mclk) disable iff (!rst_b)
      cmd_start_s |-> flash_drive_s) else $error("flash pins idle at command start");
   chain_pass_a: assert property (@(posedge mclk) disable iff (!rst_b)
      load_end_s |=> chain_pass_s) else $error("chain not passed on after load");
   init_user_a: assert property (@(posedge mclk) disable iff (!rst_b)
      init_end_s |-> q.user) else $error("init ended without user mode");
   cmd_count_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (q.st == SCL_CMD) |-> (q.bits < 16'(SCL_CMD_BITS))) else $error("command too long");
   clock_park_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (q.st == SCL_DONE) |=> (!q.sck && !q.sck_oe)) else $error("clock not parked");
   passive_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (q.latched && q.sch != SCL_ACTIVE_SERIAL) |-> (!q.sck_oe && !q.cmd_oe && q.cso_n))
      else $error("active pins driven in passive scheme");
   osc_bound_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (q.st == SCL_INIT && !q.uu_s[1]) |-> (q.cnt < 32'(CD2UM_CYC)))
      else $error("oscillator startup overran");
   uclk_bound_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (q.st == SCL_INIT && q.uu_s[1]) |-> (q.cnt <= 32'(SCL_CD2CU_PER + UM_USR_PER)))
      else $error("user clock startup overran");
   ceo_stands_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !q.ceo_n |=> !q.ceo_n) else $error("chain enable dropped");
   done_stands_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !q.cd_oe |=> !q.cd_oe) else $error("done pulled low again");
   strap_frozen_a: assert property (@(posedge mclk) disable iff (!rst_b)
      q.latched |=> ($stable(q.sch) && $stable(q.wide))) else $error("strap changed");
   status_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (q.st == SCL_IDLE && !q.st_s[1]) |=> (q.st == SCL_IDLE)) else $error("load while status low");
endmodule : scl_loader

/* core/scl_pkg.sv */
// Constants, types and timing for the serial configuration loader.
// Assumes a 200 MHz core clock and a separate configuration clock domain.
package scl_pkg;
   typedef enum logic [1:0] {
      SCL_ACTIVE_SERIAL   = 2'h0,
      SCL_PASSIVE_SERIAL  = 2'h1,
      SCL_FAST_PAR        = 2'h2,
      SCL_ACTIVE_PAR      = 2'h3
   } scl_scheme_type;

   typedef enum logic [2:0] {
      SCL_IDLE  = 3'h0,
      SCL_CMD   = 3'h1,
      SCL_LOAD  = 3'h3,
      SCL_DONE  = 3'h2,
      SCL_INIT  = 3'h6,
      SCL_USER  = 3'h7
   } scl_state_type;

   localparam int    SCL_CLK_MHZ       = 200;
   localparam int    SCL_ST2CK_US      = 2;
   localparam int    SCL_ST2CK_CYC     = SCL_ST2CK_US * SCL_CLK_MHZ;
   localparam int    SCL_CD2UM_US      = 650;
   localparam int    SCL_CD2UM_CYC     = SCL_CD2UM_US * SCL_CLK_MHZ;
   localparam int    SCL_CD2CU_PER     = 4;
   localparam int    SCL_UM_USR_PER    = 3192;
   localparam int    SCL_CMD_BITS      = 32;
   localparam int    SCL_CRC_W         = 32;
   localparam logic [7:0] SCL_READ_OP  = 8'h03;
   localparam logic [31:0] SCL_CRC_RST = 32'h0000_0000;
   localparam logic [1:0] SCL_LAT_EDGES = 2'h2;

   typedef struct packed {
      logic o;
      logic oe;
   } scl_pin_type;
endpackage : scl_pkg

/* test/scl_flash_model.sv */
// Serial flash stand-in: takes a 32-bit command, then streams an image.
// Assumes the loader drives its clock and select line.
`timescale 1ns/10ps
module scl_flash_model (
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic        cmd,
   output wire logic        data,
   output logic [31:0]      cmd_q
);
   int          n;
   logic        bit_q;
   logic [63:0] img = 64'ha5c3_0f96_1e2d_7b48;
   // Released line floats to its pull-up
   assign data = cs_n ? 1'b1 : bit_q;
   always @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         n <= 0;
      end else begin
         n <= n + 1;
         if (n < 32) cmd_q <= {cmd_q[30:0], cmd};
      end
   end
   // Change on the fall so data is steady at the rise
   always @(negedge sck) bit_q <= img[n % 64];
endmodule : scl_flash_model

/* test/scl_loader_tb.sv */
// Bench for scl_loader: active serial, passive serial, user clock startup.
// Assumes one downstream device that may hold the shared done line low.
`timescale 1ns/10ps
module scl_loader_tb;
   import scl_pkg::*;
   localparam int IMG = 64;
   logic        mclk, rst_b, cfg_clk, usr_clk, use_uc, ce_n, sdi, pwide, passive;
   logic        other_low, crc_req, ck_o, ck_oe, fs_n, fs_oe, cmd_o, cmd_oe;
   logic        st_oe, cd_oe, ceo_n, um, ib, flash_d, bad_oe;
   logic [3:0]  sel;
   logic [15:0] pdat;
   logic [31:0] crc_val, crc, op_q, crc_exp;
   logic        cmd_model[$];
   wire         ck_pin, fs_pin, cmd_pin;
   // Released pins float to their pull-ups
   assign ck_pin  = ck_oe ? ck_o : 1'b1;
   assign fs_pin  = fs_oe ? fs_n : 1'b1;
   assign cmd_pin = cmd_oe ? cmd_o : 1'b1;
   int          failures, n_checks, cyc, n_edges, seed, i;
   scl_loader #(.IMAGE_BITS(IMG), .CD2UM_CYC(50), .UM_USR_PER(8), .DIV(4)) scl_loader_inst (
      .mclk(mclk), .rst_b(rst_b), .cfg_clk_in(cfg_clk), .user_supplied_clock(usr_clk),
      .scheme_select(sel), .use_user_clock(use_uc), .chain_enable_in_n(ce_n),
      .serial_data_in(fs_oe ? flash_d : sdi), .par_data_in(pdat), .par_wide(pwide),
      .config_status_n_in(~st_oe), .config_complete_in(~(cd_oe | other_low)),
      .crc_load_req(crc_req), .crc_load_value(crc_val), .config_clock_o(ck_o),
      .config_clock_oe(ck_oe), .flash_select_n_out(fs_n), .flash_select_n_oe(fs_oe),
      .active_serial_cmd_out(cmd_o), .active_serial_cmd_oe(cmd_oe),
      .config_status_n_oe(st_oe), .config_complete_oe(cd_oe), .chain_enable_out_n(ceo_n),
      .user_mode(um), .init_busy(ib), .crc_store(crc));
   scl_flash_model scl_flash_model_inst (.sck(ck_pin), .cs_n(fs_pin), .cmd(cmd_pin),
      .data(flash_d), .cmd_q(op_q));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      usr_clk = 1'b0;
      forever #7 usr_clk = ~usr_clk;
   end
   always @(posedge ck_o) if (ck_oe) n_edges++;
   always @(posedge mclk) if (passive && rst_b && (ck_oe | cmd_oe | fs_oe)) bad_oe <= 1'b1;
   always @(posedge mclk) begin
      if (passive) begin
         sdi  <= 1'($random(seed));
         pdat <= 16'($random(seed));
      end
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic do_reset(logic [3:0] s, logic u, logic w);
      rst_b <= 1'b0;
      sel <= s;
      use_uc <= u;
      pwide <= w;
      ce_n <= 1'b1;
      other_low <= 1'b1;
      passive <= 1'b0;
      repeat (8) @(posedge mclk);
      check("rst_ceo", 1, ceo_n);
      check("rst_done_oe", 1, cd_oe);
      check("rst_um", 0, um);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      n_edges = 0;
      bad_oe = 1'b0;
   endtask : do_reset
   // Link clock runs only during a call: n pulses, including any past the image end
   task automatic link(int n);
      #1.3;
      repeat (n) begin
         #6 cfg_clk = 1'b1;
         #6 cfg_clk = 1'b0;
      end
   endtask : link
   // Host side: status must read high for the settle time before the first edge
   task automatic host_wait();
      check("status_hi", 0, st_oe);
      repeat (SCL_ST2CK_CYC) @(posedge mclk);
   endtask : host_wait
   task automatic wait_user(int lim);
      other_low <= 1'b0;
      for (i = 0; i < 6 && ib !== 1'b1; i++) @(posedge mclk);
      check("init", 1, ib);
      repeat (8) @(posedge mclk);
      check("um_early", 0, um);
      for (i = 0; i < lim && um !== 1'b1; i++) @(posedge mclk);
      check("um", 1, um);
   endtask : wait_user
   // Passive load; the model's bits per edge come from the strap and width
   task automatic passive_run(logic [3:0] s, logic u, logic w);
      int per;
      per = (s[3:2] == 2'b00) ? (w ? 16 : 8) : 1;
      do_reset(s, u, w);
      passive <= 1'b1;
      ce_n <= 1'b0;
      host_wait();
      link(IMG / per - 1);
      repeat (8) @(posedge mclk);
      check("ceo_early", 1, ceo_n);
      link(1);
      for (i = 0; i < 20 && ceo_n !== 1'b0; i++) @(posedge mclk);
      check("ceo", 0, ceo_n);
      link(5);
      repeat (8) @(posedge mclk);
      check("ceo_hold", 0, ceo_n);
      check("ps_oe", 0, bad_oe);
      wait_user(80);
   endtask : passive_run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      seed = 32'h26115dbd;
      {rst_b, cfg_clk, pwide, sdi, crc_req, passive, bad_oe} = '0;
      {pdat, crc_val, failures, n_checks, cyc} = '0;
      do_reset(4'hd, 1'b0, 1'b0);
      ce_n <= 1'b0;
      for (i = 0; i < SCL_CMD_BITS; i++) begin
         cmd_model.push_back((i < 8) ? SCL_READ_OP[7 - i] : 1'b0);
      end
      for (i = 0; i < 20 && fs_n !== 1'b0; i++) @(posedge mclk);
      check("sel_oe", 1, fs_oe);
      check("clk_oe", 1, ck_oe);
      for (i = 0; i < 2000 && ceo_n !== 1'b0; i++) @(posedge mclk);
      check("edges", SCL_CMD_BITS + IMG, n_edges);
      for (i = 31; i >= 0; i--) begin
         check("cmd_bit", 32'(cmd_model.pop_front()), 32'(op_q[i]));
      end
      check("done_oe", 0, cd_oe);
      crc_val <= $random(seed);
      crc_req <= 1'b1;
      repeat (24) @(posedge mclk);
      check("pins_oe", 0, {ck_oe, fs_oe, cmd_oe});
      check("held", 0, ib);
      crc_req <= 1'b0;
      wait_user(80);
      check("crc_refused", 0, crc);
      crc_exp = crc_val;
      crc_req <= 1'b1;
      @(posedge mclk);
      crc_req <= 1'b0;
      repeat (2) @(posedge mclk);
      check("crc", crc_exp, crc);
      $display("test active_serial ended");
      passive_run(4'h8, 1'b0, 1'b0);
      $display("test passive_serial ended");
      passive_run(4'h0, 1'b1, 1'b0);
      $display("test user_clock ended");
      passive_run(4'h0, 1'b0, 1'b1);
      $display("test word_load ended");
      tally_and_finish();
   end
endmodule : scl_loader_tb
